// ### verilog/sfs_pkg.sv
package sfs_pkg;

   // opcodes
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_CONFIG_READ = 8'h15;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;

   // status byte layout
   localparam int ST_WIP_BIT = 0;
   localparam int ST_WEL_BIT = 1;
   localparam int ST_BP_LSB = 2;
   localparam int ST_QE_BIT = 6;
   localparam logic QE_FIXED = 1'b1;

   // configuration byte layout
   localparam int CFG_ODS_LSB = 0;
   localparam int CFG_TB_BIT = 3;
   localparam int CFG_DC_LSB = 6;

   // reset values
   localparam logic [3:0] BP_RESET = 4'h0;
   localparam logic [2:0] ODS_RESET = 3'h7;
   localparam logic [1:0] DC_RESET = 2'h0;
   localparam logic TB_RESET = 1'b0;

   // frame geometry, in sclk cycles
   localparam int ADDR_W = 24;
   localparam logic [4:0] OPC_LAST = 5'h07;
   localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
   localparam logic [4:0] ADDR_LAST_DUAL = 5'h0B;
   localparam logic [3:0] TOKEN_LAST = 4'h3;
   localparam logic [4:0] WDATA_BITS_SHORT = 5'h08;
   localparam logic [4:0] WDATA_BITS_LONG = 5'h10;
   localparam logic [4:0] WDATA_CNT_MAX = 5'h1F;

   // self-timed status write cycle
   localparam int STATUS_WRITE_CYCLE_TIME_US = 5000;
   localparam int CLK_FREQ_MHZ = 25;
   localparam int STATUS_WRITE_CYCLES =
      STATUS_WRITE_CYCLE_TIME_US * CLK_FREQ_MHZ;
   localparam int TIMER_W = 24;

   typedef enum logic [1:0] {
      RD_SINGLE,
      RD_FAST,
      RD_DUAL_OUT,
      RD_DUAL_IO
   } sfs_read_t;

   function automatic logic [3:0] dummy_last(input logic [1:0] dc,
                                             input logic dual_io);
      logic [3:0] n;
      n = 4'h8;
      unique case (dc)
         2'h0: n = dual_io ? 4'h4 : 4'h8;
         2'h1: n = 4'h6;
         2'h2: n = 4'h8;
         2'h3: n = 4'hA;
      endcase
      return n - 4'h1;
   endfunction

   function automatic logic token_keeps(input logic [7:0] t);
      return t[7:4] == ~t[3:0];
   endfunction

   function automatic logic [2:0] byte_last(input logic two_wide);
      return two_wide ? 3'h3 : 3'h7;
   endfunction

endpackage

// ### verilog/sfs_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sfs_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta;

   // meta feeds o_q only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end

endmodule

`default_nettype wire

// ### verilog/sfs_flash_ctrl.sv
// What this block does
// - status write needs write enable latch set
// - reject status write unless 8/16 bits
// - cs rise starts timed cycle, then clears
// - status reads still answered during write cycle
// - block protect bits drive the sw protect flag
// - sample on rising sclk, drive on falling
// - standard read: opcode, 3-byte address, no dummy
// - address increments per byte, wraps to zero
// - cs high stops output, returns to idle
// - reads ignored while write cycle runs
// - fast read waits configured dummy cycles
// - dummy counts follow config bits 6 and 7
// - inverse-nibble token keeps enhance mode
// - other token leaves enhance after cs cycle
// - dual output read: serial address, 2-bit data
// - dual io read: 2-bit address and data
// - dummy table per config code and read type
// - write enable set by command, cleared after
// - status byte bit layout with fixed quad bit
`timescale 1ns/1ps
`default_nettype none

module sfs_flash_ctrl #(
   parameter int STATUS_WRITE_CYCLES = sfs_pkg::STATUS_WRITE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_dl0,
   output logic o_dl0,
   output logic o_dl0_oe,
   input wire logic i_dl1,
   output logic o_dl1,
   output logic o_dl1_oe,
   output logic [sfs_pkg::ADDR_W-1:0] o_mem_addr,
   input wire logic [7:0] i_mem_data,
   output logic o_write_in_progress,
   output logic o_write_enable_latch,
   output logic [3:0] o_block_protect,
   output logic o_sw_protect_active,
   output logic [1:0] o_dummy_cfg,
   output logic [2:0] o_drive_strength,
   output logic o_bottom_protect,
   output logic o_enhance_mode
);

   typedef enum logic [2:0] {
      ST_OPC,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_REG,
      ST_WDATA,
      ST_IGNORE
   } sfs_state_t;

   // link side, frame scoped state
   logic frame_rst_n;
   sfs_state_t st;
   logic [4:0] cnt;
   logic [7:0] opc;
   sfs_pkg::sfs_read_t rd;
   logic reg_sel;
   logic [sfs_pkg::ADDR_W-1:0] addr;
   logic [7:0] token;
   logic [3:0] dcnt;
   logic [2:0] pcnt;
   logic [2:0] ncnt;
   logic [7:0] dsh;

   // link side, kept across frames for the core side
   logic fr_seq;
   logic fr_opv;
   logic [7:0] fr_op;
   logic [15:0] fr_dat;
   logic [4:0] fr_cnt;

   // core side
   logic cs_s;
   logic cs_d;
   logic seq_seen;
   logic [sfs_pkg::TIMER_W-1:0] timer;
   logic [15:0] reg_view;
   logic [15:0] reg_view_s;

   logic [7:0] next_opc;
   logic [sfs_pkg::ADDR_W-1:0] next_addr;
   logic [7:0] next_token;
   logic two_wide;
   logic [2:0] blast;
   logic [3:0] dlast;
   logic wip_s;
   logic cs_rise;
   logic frame_new;

   // cs high ends everything frame scoped, sclk may be stopped
   assign frame_rst_n = i_rst_n & ~i_cs_n;

   assign next_opc = {opc[6:0], i_dl0};
   // an enhanced frame opens straight into the two-bit address
   assign next_addr = (rd == sfs_pkg::RD_DUAL_IO ||
                       (st == ST_OPC && o_enhance_mode)) ?
      {addr[sfs_pkg::ADDR_W-3:0], i_dl1, i_dl0} :
      {addr[sfs_pkg::ADDR_W-2:0], i_dl0};
   assign next_token = {token[5:0], i_dl1, i_dl0};
   assign two_wide = (st == ST_DATA) &&
      (rd == sfs_pkg::RD_DUAL_OUT || rd == sfs_pkg::RD_DUAL_IO);
   assign blast = sfs_pkg::byte_last(two_wide);
   assign dlast = sfs_pkg::dummy_last(reg_view_s[15:14],
                                      rd == sfs_pkg::RD_DUAL_IO);
   assign wip_s = reg_view_s[sfs_pkg::ST_WIP_BIT];

   // status and config byte as the link sees them
   assign reg_view = {
      o_dummy_cfg, 2'h0, o_bottom_protect, o_drive_strength,
      1'b0, sfs_pkg::QE_FIXED, o_block_protect,
      o_write_enable_latch, o_write_in_progress};

   // changes only between frames, except wip and wel falling together mid-poll
   sfs_sync #(.WIDTH(16)) u_view_sync (
      .i_clk(i_sclk),
      .i_rst_n(i_rst_n),
      .i_d(reg_view),
      .o_q(reg_view_s)
   );

   // synced as selected, so the reset value matches the idle pin
   sfs_sync #(.WIDTH(1)) u_cs_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d(~i_cs_n),
      .o_q(cs_s)
   );

   // command sequencer, rising sclk
   always_ff @(posedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         st <= ST_OPC;
         cnt <= 5'h00;
         opc <= 8'h00;
         rd <= sfs_pkg::RD_SINGLE;
         reg_sel <= 1'b0;
         addr <= 24'h00_0000;
         token <= 8'h00;
         dcnt <= 4'h0;
         pcnt <= 3'h0;
      end else begin
         unique case (st)
            ST_OPC: begin
               opc <= next_opc;
               cnt <= cnt + 5'h01;
               if (cnt == 5'h00 && o_enhance_mode) begin
                  // opcode skipped, first clock is address
                  rd <= sfs_pkg::RD_DUAL_IO;
                  addr <= next_addr;
                  st <= wip_s ? ST_IGNORE : ST_ADDR;
               end else if (cnt == sfs_pkg::OPC_LAST) begin
                  cnt <= 5'h00;
                  unique case (next_opc)
                     sfs_pkg::OP_READ: begin
                        rd <= sfs_pkg::RD_SINGLE;
                        st <= wip_s ? ST_IGNORE : ST_ADDR;
                     end
                     sfs_pkg::OP_FAST_READ: begin
                        rd <= sfs_pkg::RD_FAST;
                        st <= wip_s ? ST_IGNORE : ST_ADDR;
                     end
                     sfs_pkg::OP_DUAL_OUTPUT_READ: begin
                        rd <= sfs_pkg::RD_DUAL_OUT;
                        st <= wip_s ? ST_IGNORE : ST_ADDR;
                     end
                     sfs_pkg::OP_DUAL_IO_READ: begin
                        rd <= sfs_pkg::RD_DUAL_IO;
                        st <= wip_s ? ST_IGNORE : ST_ADDR;
                     end
                     sfs_pkg::OP_STATUS_READ: begin
                        reg_sel <= 1'b0;
                        st <= ST_REG;
                     end
                     sfs_pkg::OP_CONFIG_READ: begin
                        reg_sel <= 1'b1;
                        st <= ST_REG;
                     end
                     sfs_pkg::OP_STATUS_WRITE: st <= ST_WDATA;
                     default: st <= ST_IGNORE;
                  endcase
               end
            end
            ST_ADDR: begin
               addr <= next_addr;
               cnt <= cnt + 5'h01;
               if (cnt == ((rd == sfs_pkg::RD_DUAL_IO) ?
                           sfs_pkg::ADDR_LAST_DUAL :
                           sfs_pkg::ADDR_LAST_SINGLE)) begin
                  cnt <= 5'h00;
                  // only the standard read has no dummy phase
                  st <= (rd == sfs_pkg::RD_SINGLE) ?
                     ST_DATA : ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               dcnt <= dcnt + 4'h1;
               if (dcnt <= sfs_pkg::TOKEN_LAST) begin
                  token <= next_token;
               end
               if (dcnt == dlast) begin
                  st <= ST_DATA;
               end
            end
            ST_DATA: begin
               pcnt <= (pcnt == blast) ? 3'h0 : pcnt + 3'h1;
            end
            ST_REG, ST_WDATA, ST_IGNORE: begin
               st <= st;
            end
         endcase
      end
   end

   // array address, survives cs so the last byte stays visible
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_addr <= 24'h00_0000;
      end else if (st == ST_ADDR && rd == sfs_pkg::RD_SINGLE &&
                   cnt == sfs_pkg::ADDR_LAST_SINGLE) begin
         o_mem_addr <= next_addr;
      end else if (st == ST_DUMMY && dcnt == dlast) begin
         o_mem_addr <= addr;
      end else if (st == ST_DATA && pcnt == blast) begin
         // plain overflow of the full width wraps to zero
         o_mem_addr <= o_mem_addr + 24'h00_0001;
      end
   end

   // frame record for the core side and the enhance flag
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fr_seq <= 1'b0;
         fr_opv <= 1'b0;
         fr_op <= 8'h00;
         fr_dat <= 16'h0000;
         fr_cnt <= 5'h00;
         o_enhance_mode <= 1'b0;
      end else begin
         if (st == ST_OPC && cnt == 5'h00) begin
            fr_seq <= ~fr_seq;
            fr_opv <= 1'b0;
            fr_cnt <= 5'h00;
         end
         if (st == ST_OPC) begin
            fr_op <= next_opc;
            if (cnt == sfs_pkg::OPC_LAST && !o_enhance_mode) begin
               fr_opv <= 1'b1;
            end
         end
         if (st == ST_WDATA) begin
            fr_dat <= {fr_dat[14:0], i_dl0};
            if (fr_cnt != sfs_pkg::WDATA_CNT_MAX) begin
               fr_cnt <= fr_cnt + 5'h01;
            end
         end
         // token decides the next frame, so a cs cycle must pass
         if (st == ST_DUMMY && rd == sfs_pkg::RD_DUAL_IO &&
             dcnt == sfs_pkg::TOKEN_LAST) begin
            o_enhance_mode <=
               sfs_pkg::token_keeps(next_token);
         end
      end
   end

   // output shifter, falling sclk
   always_ff @(negedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         dsh <= 8'h00;
         ncnt <= 3'h0;
         o_dl0 <= 1'b0;
         o_dl1 <= 1'b0;
         o_dl0_oe <= 1'b0;
         o_dl1_oe <= 1'b0;
      end else if (st == ST_DATA || st == ST_REG) begin
         logic [7:0] cur;
         cur = dsh;
         if (ncnt == 3'h0) begin
            if (st == ST_REG) begin
               // live view, so polling sees wip drop
               cur = reg_sel ? reg_view_s[15:8] : reg_view_s[7:0];
            end else begin
               cur = i_mem_data;
            end
         end
         ncnt <= (ncnt == blast) ? 3'h0 : ncnt + 3'h1;
         o_dl1 <= cur[7];
         o_dl1_oe <= 1'b1;
         if (two_wide) begin
            o_dl0 <= cur[6];
            o_dl0_oe <= 1'b1;
            dsh <= {cur[5:0], 2'b00};
         end else begin
            o_dl0 <= 1'b0;
            o_dl0_oe <= 1'b0;
            dsh <= {cur[6:0], 1'b0};
         end
      end else begin
         o_dl0_oe <= 1'b0;
         o_dl1_oe <= 1'b0;
      end
   end

   // core side: acts on cs rise, frame record is static by then
   assign cs_rise = ~cs_s & cs_d;
   assign frame_new = cs_rise && fr_opv && (fr_seq != seq_seen);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_d <= 1'b0;
         seq_seen <= 1'b0;
      end else begin
         cs_d <= cs_s;
         if (cs_rise) begin
            // a cs pulse with no sclk must not replay the last frame
            seq_seen <= fr_seq;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_write_enable_latch <= 1'b0;
      end else if (frame_new && !o_write_in_progress &&
                   fr_op == sfs_pkg::OP_WRITE_ENABLE && fr_cnt == 5'h00) begin
         o_write_enable_latch <= 1'b1;
      end else if (frame_new && !o_write_in_progress &&
                   fr_op == sfs_pkg::OP_WRITE_DISABLE) begin
         o_write_enable_latch <= 1'b0;
      end else if (o_write_in_progress && timer == '0) begin
         o_write_enable_latch <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_write_in_progress <= 1'b0;
         timer <= '0;
         o_block_protect <= sfs_pkg::BP_RESET;
         o_drive_strength <= sfs_pkg::ODS_RESET;
         o_dummy_cfg <= sfs_pkg::DC_RESET;
         o_bottom_protect <= sfs_pkg::TB_RESET;
      end else if (o_write_in_progress) begin
         if (timer == '0) begin
            o_write_in_progress <= 1'b0;
         end else begin
            timer <= timer - 1'b1;
         end
      end else if (frame_new && fr_op == sfs_pkg::OP_STATUS_WRITE &&
                   o_write_enable_latch &&
                   (fr_cnt == sfs_pkg::WDATA_BITS_SHORT ||
                    fr_cnt == sfs_pkg::WDATA_BITS_LONG)) begin
         o_write_in_progress <= 1'b1;
         timer <= sfs_pkg::TIMER_W'(STATUS_WRITE_CYCLES - 1);
         if (fr_cnt == sfs_pkg::WDATA_BITS_SHORT) begin
            o_block_protect <= fr_dat[sfs_pkg::ST_BP_LSB +: 4];
         end else begin
            o_block_protect <= fr_dat[8 + sfs_pkg::ST_BP_LSB +: 4];
            o_drive_strength <= fr_dat[sfs_pkg::CFG_ODS_LSB +: 3];
            o_dummy_cfg <= fr_dat[sfs_pkg::CFG_DC_LSB +: 2];
            // one-time bit: can be set, never cleared
            o_bottom_protect <= o_bottom_protect |
               fr_dat[sfs_pkg::CFG_TB_BIT];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sw_protect_active <= 1'b0;
      end else begin
         o_sw_protect_active <= |o_block_protect;
      end
   end

endmodule

`default_nettype wire

// ### test/sfs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sfs_sva #(
   parameter int STATUS_WRITE_CYCLES = 20
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cs_n,
   input wire logic o_dl0_oe,
   input wire logic o_dl1_oe,
   input wire logic o_write_in_progress,
   input wire logic o_write_enable_latch,
   input wire logic [3:0] o_block_protect,
   input wire logic o_sw_protect_active,
   input wire logic [1:0] o_dummy_cfg,
   input wire logic [2:0] o_drive_strength
);
   logic [31:0] wcnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // length of the running write cycle, in core clocks
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) wcnt <= '0;
      else if (o_write_in_progress) wcnt <= wcnt + 32'd1;
      else wcnt <= '0;
   end
   sequence s_wr_start;
      $rose(o_write_in_progress) ##0 i_cs_n;
   endsequence
   property p_wr_start;
      s_wr_start |-> $past(o_write_enable_latch) && $past(i_cs_n, 2);
   endproperty
   a_wr_start: assert property (p_wr_start)
      else $error("write cycle started without latch or cs rise");
   property p_wel_hold;
      o_write_in_progress |-> o_write_enable_latch;
   endproperty
   a_wel_hold: assert property (p_wel_hold)
      else $error("latch cleared while write cycle runs");
   property p_wip_len;
      $fell(o_write_in_progress) |-> wcnt >= STATUS_WRITE_CYCLES - 2
         && wcnt <= STATUS_WRITE_CYCLES + 2;
   endproperty
   a_wip_len: assert property (p_wip_len)
      else $error("write cycle length wrong");
   property p_wip_max;
      wcnt <= STATUS_WRITE_CYCLES + 2;
   endproperty
   a_wip_max: assert property (p_wip_max)
      else $error("write cycle never ends");
   property p_oe_cs;
      i_cs_n |-> !o_dl0_oe && !o_dl1_oe;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("data line driven while deselected");
   property p_oe_pair;
      o_dl0_oe |-> o_dl1_oe;
   endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("line 0 driven without line 1");
   property p_prot;
      o_sw_protect_active == ($past(o_block_protect) != 4'h0);
   endproperty
   a_prot: assert property (p_prot)
      else $error("protect flag does not follow protect bits");
   property p_bp_chg;
      $changed(o_block_protect) |-> o_write_in_progress;
   endproperty
   a_bp_chg: assert property (p_bp_chg)
      else $error("protect bits changed outside a write cycle");
   property p_cfg_chg;
      $changed(o_dummy_cfg) || $changed(o_drive_strength)
         |-> o_write_in_progress;
   endproperty
   a_cfg_chg: assert property (p_cfg_chg)
      else $error("config changed outside a write cycle");
endmodule

bind sfs_flash_ctrl
   sfs_sva #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) sfs_sva_i (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
   .o_dl0_oe(o_dl0_oe), .o_dl1_oe(o_dl1_oe),
   .o_write_in_progress(o_write_in_progress),
   .o_write_enable_latch(o_write_enable_latch),
   .o_block_protect(o_block_protect),
   .o_sw_protect_active(o_sw_protect_active),
   .o_dummy_cfg(o_dummy_cfg), .o_drive_strength(o_drive_strength));

`default_nettype wire

// ### test/sfs_host.sv
`timescale 1ns/1ps
`default_nettype none

// host controller, mode 0; sclk stands low outside frames
module sfs_host (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_dl0,
   output logic o_dl1,
   input wire logic i_d0,
   input wire logic i_oe0,
   input wire logic i_d1,
   input wire logic i_oe1
);
   logic hd0 = 1'b0;
   logic hd1 = 1'b0;
   logic drv = 1'b0;
   logic drv1 = 1'b0;
   logic [63:0] rx = '0;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
   end
   // released lines flip, so a stale value can never pass
   assign o_dl0 = i_oe0 ? i_d0 : (drv ? hd0 : ~hd0);
   assign o_dl1 = i_oe1 ? i_d1 : (drv1 ? hd1 : ~hd1);
   // half-ns offset keeps cs edges off the core clock edges
   task automatic start();
      #0.5;
      o_cs_n = 1'b0;
      #3;
   endtask
   // caller picks the bit count, so a frame can end off a byte boundary
   task automatic stop();
      #3;
      o_cs_n = 1'b1;
      drv = 1'b0;
      drv1 = 1'b0;
      #200;
   endtask
   task automatic send(input logic [31:0] v, input int n, input bit two);
      for (int i = n - 1; i >= 0; i--) begin
         drv = 1'b1;
         drv1 = two;
         if (two) {hd1, hd0} = v[2*i +: 2];
         else hd0 = v[i];
         #3 o_sclk = 1'b1;
         #3 o_sclk = 1'b0;
      end
   endtask
   task automatic recv(input int n, input bit two);
      drv = 1'b0;
      drv1 = 1'b0;
      for (int i = 0; i < n; i++) begin
         #3;
         if (two) rx = {rx[61:0], o_dl1, o_dl0};
         else rx = {rx[62:0], o_dl1};
         o_sclk = 1'b1;
         #3 o_sclk = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// ### test/sfs_flash_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sfs_flash_ctrl_bench;
   typedef struct {
      logic [7:0] op;
      logic [23:0] addr;
      int dum;
      logic [23:0] data;
   } sfs_row_t;
   sfs_row_t rows [4] = '{
      '{sfs_pkg::OP_READ, 24'hFF_FFFE, 0, 24'hFE_FF00},
      '{sfs_pkg::OP_FAST_READ, 24'h00_0123, 8, 24'h22_2524},
      '{sfs_pkg::OP_DUAL_OUTPUT_READ, 24'h00_ABCD, 8, 24'h66_6564},
      '{sfs_pkg::OP_DUAL_IO_READ, 24'h12_3456, 4, 24'h70_717E}};
   logic clk, rst_n, sclk, cs_n, dl0, dl1, d0, oe0, d1, oe1;
   logic write_in_progress, write_enable_latch, swp, tb, enh;
   logic [3:0] bp;
   logic [1:0] dc;
   logic [2:0] ods;
   logic [23:0] mem_addr;
   logic [7:0] mem_data;
   logic oe_seen = 1'b0;
   int bad_count = 0;
   int cmp_count = 0;
   // toy array: each byte a function of its address
   assign mem_data = mem_addr[7:0] ^ mem_addr[15:8] ^ mem_addr[23:16];
   always @(posedge oe1) oe_seen = 1'b1;
   sfs_flash_ctrl #(.STATUS_WRITE_CYCLES(20)) sfs_flash_ctrl_i (
      .i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_dl0(dl0), .o_dl0(d0), .o_dl0_oe(oe0), .i_dl1(dl1), .o_dl1(d1),
      .o_dl1_oe(oe1), .o_mem_addr(mem_addr), .i_mem_data(mem_data),
      .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch),
      .o_block_protect(bp), .o_sw_protect_active(swp), .o_dummy_cfg(dc),
      .o_drive_strength(ods), .o_bottom_protect(tb), .o_enhance_mode(enh));
   sfs_host sfs_host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_dl0(dl0),
      .o_dl1(dl1), .i_d0(d0), .i_oe0(oe0), .i_d1(d1), .i_oe1(oe1));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [31:0] v, input int n);
      @(negedge clk);
      sfs_host_i.start();
      sfs_host_i.send(v, n, 1'b0);
      sfs_host_i.stop();
   endtask
   task automatic rdreg(input logic [7:0] op, input logic [7:0] exp);
      @(negedge clk);
      sfs_host_i.start();
      sfs_host_i.send(32'(op), 8, 1'b0);
      sfs_host_i.recv(8, 1'b0);
      sfs_host_i.stop();
      chk({16'h0000, sfs_host_i.rx[7:0]}, {16'h0000, exp});
   endtask
   task automatic rd(input logic [7:0] op, input logic [23:0] a,
                     input int dum, input logic [7:0] tok, input bit skip);
      logic two;
      two = op == sfs_pkg::OP_DUAL_OUTPUT_READ ||
         op == sfs_pkg::OP_DUAL_IO_READ;
      @(negedge clk);
      sfs_host_i.start();
      if (!skip) sfs_host_i.send(32'(op), 8, 1'b0);
      if (op == sfs_pkg::OP_DUAL_IO_READ) begin
         sfs_host_i.send(32'(a), 12, 1'b1);
         sfs_host_i.send(32'(tok), 4, 1'b1);
         sfs_host_i.recv(dum - 4, 1'b0);
      end else begin
         sfs_host_i.send(32'(a), 24, 1'b0);
         sfs_host_i.recv(dum, 1'b0);
      end
      sfs_host_i.recv(two ? 12 : 24, two);
      sfs_host_i.stop();
   endtask
   // run should take about 10 us; the limit leaves wide margin
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      foreach (rows[k]) begin
         rd(rows[k].op, rows[k].addr, rows[k].dum, 8'h00, 1'b0);
         chk(sfs_host_i.rx[23:0], rows[k].data);
      end
      rdreg(sfs_pkg::OP_STATUS_READ, 8'h40);
      cmd(32'h0000_013C, 16);
      rdreg(sfs_pkg::OP_STATUS_READ, 8'h40);
      cmd(32'h0000_0006, 8);
      rdreg(sfs_pkg::OP_STATUS_READ, 8'h42);
      cmd(32'h0000_1140, 20);
      rdreg(sfs_pkg::OP_STATUS_READ, 8'h42);
      cmd(32'h0001_1447, 24);
      rdreg(sfs_pkg::OP_STATUS_READ, 8'h57);
      oe_seen = 1'b0;
      rd(sfs_pkg::OP_READ, 24'h00_0040, 0, 8'h00, 1'b0);
      chk(24'(oe_seen), 24'h00_0000);
      repeat (100) if (write_in_progress === 1'b1) @(negedge clk);
      chk(24'({swp, write_enable_latch, write_in_progress, dc, bp}), 24'h00_0115);
      rdreg(sfs_pkg::OP_CONFIG_READ, 8'h47);
      rd(sfs_pkg::OP_FAST_READ, 24'h00_0030, 6, 8'h00, 1'b0);
      chk(sfs_host_i.rx[23:0], 24'h30_3132);
      rd(sfs_pkg::OP_DUAL_IO_READ, 24'h00_0010, 6, 8'hA5, 1'b0);
      chk(sfs_host_i.rx[23:0], 24'h10_1112);
      chk(24'(enh), 24'h00_0001);
      rd(sfs_pkg::OP_DUAL_IO_READ, 24'h00_0020, 6, 8'hFF, 1'b1);
      chk(sfs_host_i.rx[23:0], 24'h20_2122);
      chk(24'(enh), 24'h00_0000);
      // abort in mid-byte, then the next command must still work
      @(negedge clk);
      sfs_host_i.start();
      sfs_host_i.send(32'(sfs_pkg::OP_READ), 8, 1'b0);
      sfs_host_i.send(32'h0000_0050, 24, 1'b0);
      sfs_host_i.recv(4, 1'b0);
      sfs_host_i.stop();
      chk(24'({oe0, oe1}), 24'h00_0000);
      rdreg(sfs_pkg::OP_STATUS_READ, 8'h54);
      stop_test();
   end
endmodule

`default_nettype wire
